// ### chg_mode_ctrl.sv
// Purpose: mode control of a single-cell charger
// Assumes: pins are asynchronous; comparators give clean levels
// Notes:   timer limits are parameters so simulation can shorten them
`timescale 1ns/100ps
`default_nettype none
`include "chg_regs.svh"
module chg_mode_ctrl
   import chg_pkg::*;
#(
   parameter int unsigned TICK_CYC       = `CHG_TICK_NS / `CHG_CLK_NS,
   parameter int unsigned PREQUAL_TICKS  =
      `CHG_PREQUAL_MIN * `CHG_MS_PER_MIN,
   parameter int unsigned FULL_SHORT_TICKS =
      `CHG_FULL_SHORT_HR * `CHG_MS_PER_HR,
   parameter int unsigned FULL_LONG_TICKS =
      `CHG_FULL_LONG_HR * `CHG_MS_PER_HR,
   parameter int unsigned TOPOFF_SHORT_TICKS =
      `CHG_TOPOFF_SHORT_MIN * `CHG_MS_PER_MIN,
   parameter int unsigned TOPOFF_LONG_TICKS =
      `CHG_TOPOFF_LONG_MIN * `CHG_MS_PER_MIN,
   parameter int unsigned DEGLITCH_TICKS = `CHG_DEGLITCH_MS
)
(
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        charge_disable_in,
   input  wire logic        rate_select_in,
   input  wire logic        temp_hot_in,
   input  wire logic        temp_cold_in,
   input  wire logic        thermistor_sense_float_in,
   input  wire logic        wall_adapter_input_in,
   input  wire logic        bus_power_input_in,
   input  wire logic        batt_full_rate_in,
   input  wire logic        end_of_charge_in,
   input  wire logic        topoff_current_in,
   input  wire logic        below_recharge_threshold_in,
   output logic             status_out_a_out,
   output logic             status_out_a_oe_out,
   output logic             status_out_b_out,
   output logic             status_out_b_oe_out,
   output logic             charge_enable_out,
   output logic             linear_regulator_mode_out,
   output logic             high_current_out,
   output logic             source_wall_out,
   output logic             source_bus_out
);
   // =====================================================================
   // helpers
   function automatic logic [1:0] chg_status(input chg_state_e st);
      logic [1:0] s;
      s = 2'h0;
      unique case (st)
         ST_PREQUAL, ST_FULL, ST_TOPOFF: s = 2'h2;
         ST_DONE:                        s = 2'h1;
         ST_BADBAT, ST_LDO:              s = 2'h3;
         default:                        s = 2'h0;
      endcase
      return s;
   endfunction

   function automatic logic chg_charging(input chg_state_e st);
      return (st == ST_PREQUAL) || (st == ST_FULL) ||
             (st == ST_TOPOFF) || (st == ST_DONE);
   endfunction

   function automatic logic chg_timing(input chg_state_e st);
      return (st == ST_PREQUAL) || (st == ST_FULL) || (st == ST_TOPOFF);
   endfunction

   localparam chg_count_t PREQ_LIM = 26'(PREQUAL_TICKS);
   localparam chg_count_t FULL_S   = 26'(FULL_SHORT_TICKS);
   localparam chg_count_t FULL_L   = 26'(FULL_LONG_TICKS);
   localparam chg_count_t TOP_S    = 26'(TOPOFF_SHORT_TICKS);
   localparam chg_count_t TOP_L    = 26'(TOPOFF_LONG_TICKS);
   localparam chg_count_t DG_LIM   = 26'(DEGLITCH_TICKS);
   localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);

   // =====================================================================
   // pin synchronisers
   logic [10:0] sync1_reg;
   logic [10:0] sync2_reg;
   logic [10:0] sync1_next;
   logic [10:0] sync2_next;

   always_comb begin
      sync1_next = {charge_disable_in, rate_select_in, temp_hot_in,
                    temp_cold_in, thermistor_sense_float_in,
                    wall_adapter_input_in, bus_power_input_in,
                    batt_full_rate_in, end_of_charge_in,
                    topoff_current_in, below_recharge_threshold_in};
      sync2_next = sync1_reg;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   logic dis_s, sel_s, hot_s, cold_s, float_s, wall_s, bus_s;
   logic vfull_s, eoc_s, topc_s, restart_s;
   assign {dis_s, sel_s, hot_s, cold_s, float_s, wall_s, bus_s,
           vfull_s, eoc_s, topc_s, restart_s} = sync2_reg;

   // =====================================================================
   // control register and tick prescaler
   logic [1:0]  ctrl_reg;
   logic [1:0]  ctrl_next;
   logic [14:0] pre_reg;
   logic [14:0] pre_next;
   logic        tick;
   logic        bus_req;
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   assign tick = (pre_reg == TICK_LAST);
   assign bus_req = avs_read_in || avs_write_in;

   // =====================================================================
   // mode state machine
   chg_state_e state_reg, state_next;
   chg_state_e resume_reg, resume_next;
   chg_state_e phase_reg, phase_next;
   chg_src_e   src_reg, src_next;
   logic [1:0] stat_reg, stat_next;
   logic [5:0] out_reg, out_next;
   chg_count_t tmr_count;
   chg_count_t dg_count;
   chg_count_t tmr_lim;
   logic       temp_bad, src_ok, ldo_go, tmr_clear, tmr_en, expired;
   logic       dg_clear, dg_en;

   always_comb begin
      temp_bad = hot_s || cold_s || float_s;
      src_ok = (src_reg == SRC_WALL && wall_s) ||
               (src_reg == SRC_BUS && bus_s);
      ldo_go = ctrl_reg[`CHG_CTRL_LDO_BIT] && src_reg == SRC_WALL &&
               float_s && dg_count >= DG_LIM;
      unique case (state_reg)
         ST_PREQUAL: tmr_lim = PREQ_LIM;
         ST_FULL: tmr_lim = (ctrl_reg[`CHG_CTRL_SEL_BIT] && !sel_s) ?
                            FULL_L : FULL_S;
         ST_TOPOFF: tmr_lim = (ctrl_reg[`CHG_CTRL_SEL_BIT] && !sel_s) ?
                              TOP_L : TOP_S;
         default: tmr_lim = '1;
      endcase
      expired = tmr_count >= tmr_lim;
      state_next = state_reg;
      resume_next = resume_reg;
      src_next = src_reg;
      unique case (state_reg)
         ST_PWRDN: begin
            src_next = SRC_NONE;
            if (wall_s || bus_s) begin
               state_next = ST_SRCSEL;
            end
         end
         ST_SRCSEL: begin
            if (wall_s) begin
               src_next = SRC_WALL;
               state_next = ST_PREQUAL;
            end else if (bus_s) begin
               src_next = SRC_BUS;
               state_next = ST_PREQUAL;
            end else begin
               state_next = ST_PWRDN;
            end
         end
         ST_PREQUAL, ST_FULL, ST_TOPOFF, ST_DONE: begin
            if (ldo_go) begin
               state_next = ST_LDO;
            end else if (temp_bad) begin
               state_next = ST_SUSPEND;
               resume_next = state_reg;
            end else if (dis_s) begin
               state_next = ST_INTR;
               resume_next = state_reg;
            end else if (state_reg == ST_PREQUAL) begin
               if (vfull_s) begin
                  state_next = ST_FULL;
               end else if (expired) begin
                  state_next = ST_BADBAT;
               end
            end else if (state_reg == ST_FULL) begin
               if (eoc_s) begin
                  state_next = ST_TOPOFF;
               end else if (expired) begin
                  state_next = ST_BADBAT;
               end
            end else if (state_reg == ST_TOPOFF) begin
               if (topc_s || expired) begin
                  state_next = ST_DONE;
               end
            end else if (restart_s) begin
               state_next = ST_FULL;
            end
         end
         ST_SUSPEND: begin
            if (ldo_go) begin
               state_next = ST_LDO;
            end else if (!temp_bad) begin
               state_next = dis_s ? ST_INTR : resume_reg;
            end
         end
         ST_INTR: begin
            if (ldo_go) begin
               state_next = ST_LDO;
            end else if (temp_bad) begin
               state_next = ST_SUSPEND;
            end else if (!dis_s) begin
               state_next = resume_reg;
            end
         end
         ST_BADBAT: state_next = ST_BADBAT;
         ST_LDO: begin
            if (!float_s) begin
               state_next = ST_SRCSEL;
            end
         end
         default: state_next = ST_PWRDN;
      endcase
      // losing the source ends everything, bad battery included
      if (state_reg != ST_PWRDN && state_reg != ST_SRCSEL && !src_ok) begin
         state_next = ST_PWRDN;
         src_next = SRC_NONE;
      end
      // timer belongs to one phase; a different phase starts it afresh
      if (chg_charging(state_next)) begin
         phase_next = state_next;
      end else if (state_next == ST_SUSPEND || state_next == ST_INTR) begin
         phase_next = phase_reg;
      end else begin
         phase_next = ST_PWRDN;
      end
      tmr_clear = chg_charging(state_next) &&
                  state_next != phase_reg;
      tmr_en = tick && chg_timing(state_reg) &&
               state_next == state_reg;
      dg_clear = !float_s || src_reg != SRC_WALL;
      dg_en = tick && ctrl_reg[`CHG_CTRL_LDO_BIT];
      stat_next = chg_status(state_next);
      out_next = {chg_timing(state_next), state_next == ST_LDO,
                  src_next == SRC_BUS && sel_s,
                  src_next == SRC_WALL, src_next == SRC_BUS, 1'b0};
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         state_reg <= ST_PWRDN;
         resume_reg <= ST_PWRDN;
         phase_reg <= ST_PWRDN;
         src_reg <= SRC_NONE;
         stat_reg <= 2'h0;
         out_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         resume_reg <= resume_next;
         phase_reg <= phase_next;
         src_reg <= src_next;
         stat_reg <= stat_next;
         out_reg <= out_next;
      end
   end

   chg_hold_counter u_safety_timer (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .clear_in   (tmr_clear),
      .enable_in  (tmr_en),
      .count_out  (tmr_count)
   );

   chg_hold_counter u_deglitch (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .clear_in   (dg_clear),
      .enable_in  (dg_en),
      .count_out  (dg_count)
   );

   // =====================================================================
   // outputs
   assign status_out_a_out    = 1'b0;
   assign status_out_b_out    = 1'b0;
   assign status_out_a_oe_out = stat_reg[1];
   assign status_out_b_oe_out = stat_reg[0];
   assign charge_enable_out   = out_reg[5];
   assign linear_regulator_mode_out = out_reg[4];
   assign high_current_out    = out_reg[3];
   assign source_wall_out     = out_reg[2];
   assign source_bus_out      = out_reg[1];

   // =====================================================================
   // register bus slave
   always_comb begin
      pre_next = tick ? 15'h0000 : pre_reg + 15'h0001;
      ack_next = bus_req && !ack_reg;
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      // a write lands where waitrequest is seen low
      if (avs_write_in && ack_reg && avs_address_in == `CHG_CTRL_OFS &&
          avs_byteenable_in[0]) begin
         ctrl_next = avs_writedata_in[1:0];
      end
      if (bus_req && !ack_reg) begin
         rdata_next = 32'h0000_0000;
         if (avs_read_in) begin
            unique case (avs_address_in)
               `CHG_CTRL_OFS: rdata_next = {30'h0, ctrl_reg};
               `CHG_STAT_OFS: rdata_next = {18'h0, stat_reg, src_reg,
                                            state_reg};
               `CHG_TIMER_OFS: rdata_next = {6'h00, tmr_count};
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pre_reg <= 15'h0000;
         ack_reg <= 1'b0;
         ctrl_reg <= `CHG_CTRL_RST;
         rdata_reg <= 32'h0000_0000;
      end else begin
         pre_reg <= pre_next;
         ack_reg <= ack_next;
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   assign avs_waitrequest_out = bus_req && !ack_reg;
   assign avs_readdata_out    = rdata_reg;

   // =====================================================================
   // assertions
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   a_temp_suspend: assert property (
      chg_charging(state_reg) && temp_bad && !ldo_go && src_ok
      |=> state_reg == ST_SUSPEND ##0 !status_out_a_oe_out
          && !status_out_b_oe_out)
      else $error("temperature fault did not suspend");
   a_timer_hold: assert property (
      state_reg == ST_SUSPEND && $past(state_reg) == ST_SUSPEND
      |-> $stable(tmr_count))
      else $error("timer moved during suspend");
   a_no_source: assert property (
      state_reg == ST_PWRDN |=> state_reg inside {ST_PWRDN, ST_SRCSEL})
      else $error("left power-down without selection");
   a_float_hot: assert property (
      chg_charging(state_reg) && float_s && src_ok &&
      !ctrl_reg[`CHG_CTRL_LDO_BIT] |=> state_reg == ST_SUSPEND)
      else $error("floating input did not suspend");
   a_intr_enter: assert property (
      chg_charging(state_reg) && dis_s && !temp_bad && src_ok && !ldo_go
      |=> state_reg == ST_INTR)
      else $error("disable did not interrupt");
   a_intr_hold: assert property (
      state_reg == ST_INTR |-> $stable(tmr_count) && !status_out_a_oe_out
      && !status_out_b_oe_out)
      else $error("interrupt state not held");
   a_ldo_status: assert property (
      state_reg == ST_LDO |-> status_out_a_oe_out && status_out_b_oe_out
      && linear_regulator_mode_out)
      else $error("regulator mode status wrong");
   a_ldo_wall: assert property (
      state_reg == ST_LDO |-> src_reg == SRC_WALL)
      else $error("regulator mode on bus power");
   a_deglitch_wait: assert property (
      $rose(state_reg == ST_LDO) |-> $past(dg_count) >= DG_LIM)
      else $error("regulator mode before deglitch");
   a_bad_stays: assert property (
      state_reg == ST_BADBAT && src_ok |=> state_reg == ST_BADBAT)
      else $error("bad battery left with source");
   a_src_first: assert property (
      state_reg == ST_SRCSEL && wall_s |=> src_reg == SRC_WALL)
      else $error("adapter not preferred");
   a_cur_sel: assert property (
      src_reg == SRC_WALL |-> !high_current_out)
      else $error("select drove current on adapter");
   a_resume_same: assert property (
      state_reg inside {ST_SUSPEND, ST_INTR} ##1
      state_reg == $past(resume_reg) |-> tmr_count == $past(tmr_count))
      else $error("timer not resumed from count");

   c_full_charge: cover property (state_reg == ST_TOPOFF ##1
                                  state_reg == ST_DONE);
   c_suspend_back: cover property (state_reg == ST_SUSPEND ##1
                                   state_reg == ST_FULL);
   c_ldo: cover property (state_reg == ST_LDO);
   c_bad: cover property (state_reg == ST_BADBAT);
endmodule // chg_mode_ctrl
`default_nettype wire

// ### chg_regs.svh
// Purpose: constants for the charger mode controller
// Assumes: 20 MHz clock, 1 ms timer tick
// Notes:   offsets are byte addresses on the register bus
//
// Overview of operation
// - temperature out of window suspends charging; both status outputs off.
// - during temperature suspend the safety timer keeps its present count.
// - thermistor checked only while charging, never without a power source; the code also checks it in charge interrupt.
// - floating thermistor input counts as above the upper temperature limit.
// - disable pin high interrupts charging; low resumes; may be tied low.
// - in charge interrupt the timer holds and both status outputs are off.
// - regulator variant: thermistor floating on adapter, regulator mode.
// - regulator mode never entered while running from bus power.
// - no regulator variant: floating thermistor gives temperature suspend.
// - timer variant: select high gives five hours, low gives ten hours.
// - on bus power select sets current and timer; on adapter only timer.
// - thermistor must float for the deglitch interval before regulator mode.
// - temperature suspend reachable only from prequal, full, top-off, done and interrupt.
// - bad battery holds until the input power source is removed.
// - source selection tries the adapter first, then bus power.
// - status: off/off idle, on/off charging, off/on done, on/on fault.
// - an on status output pulls its pin low; off releases it.
// - held timer resumes its count only when the same phase returns.
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH

// =====================================================================
// register map
`define CHG_CTRL_OFS       4'h0
`define CHG_STAT_OFS       4'h4
`define CHG_TIMER_OFS      4'h8
`define CHG_CTRL_LDO_BIT   0
`define CHG_CTRL_SEL_BIT   1
`define CHG_CTRL_RST       2'h0
`define CHG_STAT_SRC_LSB   10
`define CHG_STAT_PIN_LSB   12

// =====================================================================
// timing
`define CHG_CLK_NS         50
`define CHG_TICK_NS        1000000
`define CHG_MS_PER_MIN     60000
`define CHG_MS_PER_HR      3600000
`define CHG_PREQUAL_MIN    30
`define CHG_FULL_SHORT_HR  5
`define CHG_FULL_LONG_HR   10
`define CHG_TOPOFF_SHORT_MIN 30
`define CHG_TOPOFF_LONG_MIN  60
`define CHG_DEGLITCH_MS    300

`endif

// ### chg_pkg.sv
// Purpose: shared types of the charger mode controller
// Assumes: nothing
// Notes:   states are one-hot
`default_nettype none
package chg_pkg;
   typedef enum logic [9:0] {
      ST_PWRDN   = 10'h001,
      ST_SRCSEL  = 10'h002,
      ST_PREQUAL = 10'h004,
      ST_FULL    = 10'h008,
      ST_TOPOFF  = 10'h010,
      ST_DONE    = 10'h020,
      ST_SUSPEND = 10'h040,
      ST_INTR    = 10'h080,
      ST_BADBAT  = 10'h100,
      ST_LDO     = 10'h200
   } chg_state_e;
   typedef enum logic [1:0] {
      SRC_NONE = 2'h0,
      SRC_WALL = 2'h1,
      SRC_BUS  = 2'h2
   } chg_src_e;
   typedef logic [25:0] chg_count_t;
endpackage
`default_nettype wire

// ### chg_hold_counter.sv
// Purpose: tick counter that holds its count while not enabled
// Assumes: enable is a one-cycle tick
// Notes:   clear wins over enable
`timescale 1ns/100ps
`default_nettype none
module chg_hold_counter
   import chg_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       nrst_in,
   input  wire logic       clear_in,
   input  wire logic       enable_in,
   output logic [25:0]     count_out
);
   chg_count_t count_reg;
   chg_count_t count_next;

   // =====================================================================
   // count
   always_comb begin
      count_next = count_reg;
      if (clear_in) begin
         count_next = '0;
      end else if (enable_in && count_reg != '1) begin
         count_next = count_reg + 26'h1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count_out = count_reg;
endmodule // chg_hold_counter
`default_nettype wire

// ### chg_far_side.sv
// Purpose: far side of the charger: thermistor, battery, pull-ups
// Assumes: inputs change just after a clock edge
// Notes:   levels only, no analog behaviour
`timescale 1ns/100ps
`default_nettype none
module chg_far_side (
   input  wire logic       hot_cmd_in,
   input  wire logic       cold_cmd_in,
   input  wire logic       removed_in,
   input  wire logic [1:0] phase_in,
   input  wire logic       oe_a_in,
   input  wire logic       oe_b_in,
   output logic            hot_out,
   output logic            cold_out,
   output logic            float_out,
   output logic            full_rate_out,
   output logic            eoc_out,
   output logic            topoff_out,
   output logic            pin_a_out,
   output logic            pin_b_out
);
   // =========
   // battery pack
   assign hot_out       = hot_cmd_in;
   assign cold_out      = cold_cmd_in;
   assign float_out     = removed_in;
   assign full_rate_out = phase_in >= 2'h1;
   assign eoc_out       = phase_in >= 2'h2;
   assign topoff_out    = phase_in == 2'h3;
   // =========
   // pull-ups on the open-drain pins
   assign pin_a_out     = oe_a_in ? 1'b0 : 1'b1;
   assign pin_b_out     = oe_b_in ? 1'b0 : 1'b1;
endmodule // chg_far_side
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench of the charger mode controller
// Assumes: shortened timer parameters, tick of 4 clocks
// Notes:   registers read over the register bus
`timescale 1ns/100ps
`default_nettype none
`include "chg_regs.svh"
module tb;
   import chg_pkg::*;
   localparam logic [3:0] CTL = `CHG_CTRL_OFS;
   localparam logic [3:0] STA = `CHG_STAT_OFS;
   localparam logic [3:0] TMR = `CHG_TIMER_OFS;
   logic        ref_clk, nrst, rd, wr, dis, sel, hot, cold, rem, wall, bus;
   logic        sag, hi, ce, lro, oe_a, oe_b, wreq, pa, pb;
   logic        hot_w, cold_w, flt_w, fr_w, eoc_w, top_w;
   logic        sa, sb, swl, sbs;
   chg_src_e    sk;
   logic [1:0]  ph;
   logic [3:0]  adr, be;
   logic [31:0] wd, rdat, q, t0;
   int          n_mismatch, n_tests;
   chg_mode_ctrl #(.TICK_CYC(4), .PREQUAL_TICKS(40), .FULL_SHORT_TICKS(20),
      .FULL_LONG_TICKS(40), .TOPOFF_SHORT_TICKS(10),
      .TOPOFF_LONG_TICKS(20), .DEGLITCH_TICKS(10)) u_chg_mode_ctrl (
      .ref_clk_in(ref_clk), .nrst_in(nrst), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .charge_disable_in(dis),
      .rate_select_in(sel), .temp_hot_in(hot_w), .temp_cold_in(cold_w),
      .thermistor_sense_float_in(flt_w), .wall_adapter_input_in(wall),
      .bus_power_input_in(bus), .batt_full_rate_in(fr_w),
      .end_of_charge_in(eoc_w), .topoff_current_in(top_w),
      .below_recharge_threshold_in(sag), .status_out_a_out(sa),
      .status_out_a_oe_out(oe_a), .status_out_b_out(sb),
      .status_out_b_oe_out(oe_b), .charge_enable_out(ce),
      .linear_regulator_mode_out(lro), .high_current_out(hi),
      .source_wall_out(swl), .source_bus_out(sbs));
   chg_far_side u_chg_far_side (.hot_cmd_in(hot), .cold_cmd_in(cold),
      .removed_in(rem), .phase_in(ph), .oe_a_in(oe_a), .oe_b_in(oe_b),
      .hot_out(hot_w), .cold_out(cold_w), .float_out(flt_w),
      .full_rate_out(fr_w), .eoc_out(eoc_w), .topoff_out(top_w),
      .pin_a_out(pa), .pin_b_out(pb));
   // =========
   // tasks
   task automatic go(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
         n_mismatch++;
      end
   endtask
   task automatic bus_op(input logic w, input logic [3:0] a,
                         input logic [31:0] d);
      @(posedge ref_clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge ref_clk);
      end while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      bus_op(1'b0, a, 32'h0);
      cmp(e, q);
   endtask
   function automatic logic [31:0] sw(input chg_state_e s,
                                      input chg_src_e c, input logic [1:0] ab);
      return {18'h0, ab, c, s};
   endfunction
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // =========
   // clock, watchdog, tests
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      go(20000);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      {nrst, rd, wr, dis, sel, hot, cold, rem, wall, bus, sag} = '0;
      ph = 2'h0;
      adr = 4'h0;
      be = 4'hf;
      wd = 32'h0;
      go(2);
      nrst <= 1'b1;
      rdc(STA, sw(ST_PWRDN, SRC_NONE, 2'h0));
      rdc(CTL, 32'h0);
      bus_op(1'b1, 4'hc, 32'hffff_ffff);
      rdc(4'hc, 32'h0);
      be <= 4'he;
      bus_op(1'b1, CTL, 32'h3);
      be <= 4'hf;
      rdc(CTL, 32'h0);
      $display("test 1 done");
      wall <= 1'b1;
      bus <= 1'b1;
      go(8);
      rdc(STA, sw(ST_PREQUAL, SRC_WALL, 2'h2));
      cmp({30'h0, pa, pb}, 32'h1);
      cmp({28'h0, sa, sb, swl, sbs}, 32'h2);
      go(30);
      for (int k = 0; k < 3; k++) begin
         hot <= (k == 0);
         cold <= (k == 1);
         dis <= (k == 2);
         go(6);
         rdc(STA, sw(k < 2 ? ST_SUSPEND : ST_INTR, SRC_WALL, 2'h0));
         cmp({31'h0, ce}, 32'h0);
         bus_op(1'b0, TMR, 32'h0);
         t0 = q;
         go(12);
         rdc(TMR, t0);
         {hot, cold, dis} <= 3'h0;
         go(8);
         bus_op(1'b0, TMR, 32'h0);
         cmp({31'h0, q > t0 && q < t0 + 32'h6}, 32'h1);
      end
      $display("test 2 done");
      ph <= 2'h1;
      go(6);
      rdc(STA, sw(ST_FULL, SRC_WALL, 2'h2));
      ph <= 2'h2;
      go(6);
      rdc(STA, sw(ST_TOPOFF, SRC_WALL, 2'h2));
      ph <= 2'h3;
      go(6);
      rdc(STA, sw(ST_DONE, SRC_WALL, 2'h1));
      bus_op(1'b1, CTL, 32'h2);
      ph <= 2'h1;
      sag <= 1'b1;
      go(6);
      sag <= 1'b0;
      go(120);
      rdc(STA, sw(ST_FULL, SRC_WALL, 2'h2));
      go(80);
      rdc(STA, sw(ST_BADBAT, SRC_WALL, 2'h3));
      ph <= 2'h0;
      go(20);
      rdc(STA, sw(ST_BADBAT, SRC_WALL, 2'h3));
      wall <= 1'b0;
      bus <= 1'b0;
      go(6);
      rdc(STA, sw(ST_PWRDN, SRC_NONE, 2'h0));
      $display("test 3 done");
      sel <= 1'b1;
      bus <= 1'b1;
      ph <= 2'h1;
      go(10);
      cmp({31'h0, hi}, 32'h1);
      cmp({30'h0, swl, sbs}, 32'h1);
      rdc(STA, sw(ST_FULL, SRC_BUS, 2'h2));
      go(100);
      rdc(STA, sw(ST_BADBAT, SRC_BUS, 2'h3));
      bus <= 1'b0;
      ph <= 2'h0;
      go(6);
      $display("test 4 done");
      for (int k = 0; k < 3; k++) begin
         sk = (k == 1) ? SRC_BUS : SRC_WALL;
         bus_op(1'b1, CTL, {31'h0, k < 2});
         wall <= (k != 1);
         bus <= (k == 1);
         go(8);
         rem <= 1'b1;
         go(20);
         rdc(STA, sw(ST_SUSPEND, k == 1 ? SRC_BUS : SRC_WALL, 2'h0));
         go(60);
         if (k == 0) begin
            rdc(STA, sw(ST_LDO, SRC_WALL, 2'h3));
         end else begin
            rdc(STA, sw(ST_SUSPEND, sk, 2'h0));
         end
         cmp({31'h0, lro}, {31'h0, k == 0});
         cmp({31'h0, hi}, {31'h0, k == 1});
         rem <= 1'b0;
         wall <= 1'b0;
         bus <= 1'b0;
         go(8);
      end
      $display("test 5 done");
      end_of_test();
   end
endmodule // tb
`default_nettype wire
